// ==== core/bst_params.svh ====
`ifndef BST_PARAMS_SVH
`define BST_PARAMS_SVH

// instruction codes (3-bit instruction register)
`define BST_IR_WIDTH        3
`define BST_INS_EXTEST      3'h0
`define BST_INS_IDCODE      3'h1
`define BST_INS_SAMPLE_Z    3'h2
`define BST_INS_SAMPLE_PRE  3'h4
`define BST_INS_BYPASS      3'h7
// capture pattern for the two low instruction bits
`define BST_IR_CAPTURE      3'h1
// reset value of the instruction register
`define BST_IR_RESET        3'h1
// identification register width and arbitrary identity value
`define BST_ID_WIDTH        32
`define BST_ID_VALUE        32'h0a5a5001
// default boundary register length
`define BST_BSR_LEN         8
// rising test clock edges with mode select high that reach reset from any state
`define BST_RESET_EDGES     5

`endif

// ==== core/bst_pkg.sv ====
`default_nettype none
package bst_pkg;

  typedef enum logic [3:0] {
    ST_RESET      = 4'h0,
    ST_IDLE       = 4'h1,
    ST_SEL_DR     = 4'h2,
    ST_CAP_DR     = 4'h3,
    ST_SHIFT_DR   = 4'h4,
    ST_EXIT1_DR   = 4'h5,
    ST_PAUSE_DR   = 4'h6,
    ST_EXIT2_DR   = 4'h7,
    ST_UPDATE_DR  = 4'h8,
    ST_SEL_IR     = 4'h9,
    ST_CAP_IR     = 4'ha,
    ST_SHIFT_IR   = 4'hb,
    ST_EXIT1_IR   = 4'hc,
    ST_PAUSE_IR   = 4'hd,
    ST_EXIT2_IR   = 4'he,
    ST_UPDATE_IR  = 4'hf
  } bst_state_type;

endpackage : bst_pkg
`default_nettype wire

// ==== core/bst_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser with a chosen reset level
module bst_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // level in and out
  input  wire logic din,
  output logic      dout
);

  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule : bst_sync
`default_nettype wire

// ==== core/bst_tap.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "bst_params.svh"

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// [R1] standard sixteen-state test port controller stepped by mode select
// [R2] controller with instruction, boundary, bypass and identification registers
// [R3] all test inputs taken on rising test clock; test clock drives tap only
// [R4] all test outputs, serial output included, change on falling test clock
// [R5] mode select sampled each rising test clock edge steers state changes
// [R6] mode select pulled up internally; open pin reads high
// [R7] serial input pulled up internally; may stay unconnected
// [R8] exactly one register between serial in and out, chosen by instruction
// [R9] serial input feeds register msb; serial output taken from register lsb
// [R10] serial output enabled only in shift states, otherwise released
// [R11] mode select high for five rising edges puts controller in reset
// [R12] tap reset never touches memory function
// [R13] power-up resets tap so serial output starts released
// [R14] board disables port by holding test clock low, output open
// [R15] three-bit instruction register loads identify at power-up and reset state
// [R16] capture-instruction loads binary 01 into two low instruction bits
// [R17] bypass register is one bit, minimal path when bypass selected
// [R18] identify instruction: capture hardwired code, shift it out in shift-data
// [R19] instruction and data updates take effect on falling test clock edge
module bst_tap #(
  parameter int BSR_LEN = `BST_BSR_LEN
) (
  // system clock and reset
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  // test port pins
  input  wire logic               tck,
  input  wire logic               tms,
  input  wire logic               tms_pu_n,
  input  wire logic               tdi,
  input  wire logic               tdi_pu_n,
  output logic                    tdo_o,
  output logic                    tdo_oe,
  // memory pin ring
  input  wire logic [BSR_LEN-1:0] ring_in,
  output logic [BSR_LEN-1:0]      bsr_out,
  output logic                    extest_en,
  output logic                    out_hiz
);

  // the shift path needs at least two cells to split msb and lsb
  if (BSR_LEN < 2) begin : g_bad_len
    $error("boundary register too short");
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin sampling; an open pin (pull-up enable high) reads high
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic tms_pin;
  logic tdi_pin;

  assign tms_pin = tms | tms_pu_n;  // [R6]
  assign tdi_pin = tdi | tdi_pu_n;  // [R7]

  bst_sync #(.RST_VAL(1'b0)) u_sync_tck (
    .clk_sys(clk_sys), .resetn(resetn), .din(tck), .dout(tck_s));
  bst_sync #(.RST_VAL(1'b1)) u_sync_tms (
    .clk_sys(clk_sys), .resetn(resetn), .din(tms_pin), .dout(tms_s));
  bst_sync #(.RST_VAL(1'b1)) u_sync_tdi (
    .clk_sys(clk_sys), .resetn(resetn), .din(tdi_pin), .dout(tdi_s));

  // ring bits live in the memory domain; a bit moving at capture may read either way
  logic [BSR_LEN-1:0] ring_s;

  for (genvar gi = 0; gi < BSR_LEN; gi++) begin : g_ring_sync
    bst_sync #(.RST_VAL(1'b0)) u_sync_ring (
      .clk_sys(clk_sys), .resetn(resetn), .din(ring_in[gi]), .dout(ring_s[gi]));
  end

  // edge detection; a test clock held low yields no edges at all [R14]
  logic tck_q;
  logic rise;
  logic fall;

  assign rise = tck_s & ~tck_q;  // [R3]
  assign fall = ~tck_s & tck_q;  // [R4]

  //////////////////////////////////////////////////////////////////////////////
  // controller state
  bst_pkg::bst_state_type st_q;
  bst_pkg::bst_state_type st_d;

  always_comb begin
    st_d = st_q;
    if (rise) begin  // [R5]
      unique case (st_q)
        bst_pkg::ST_RESET:     st_d = tms_s ? bst_pkg::ST_RESET   : bst_pkg::ST_IDLE;
        bst_pkg::ST_IDLE:      st_d = tms_s ? bst_pkg::ST_SEL_DR  : bst_pkg::ST_IDLE;
        bst_pkg::ST_SEL_DR:    st_d = tms_s ? bst_pkg::ST_SEL_IR  : bst_pkg::ST_CAP_DR;
        bst_pkg::ST_CAP_DR:    st_d = tms_s ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
        bst_pkg::ST_SHIFT_DR:  st_d = tms_s ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
        bst_pkg::ST_EXIT1_DR:  st_d = tms_s ? bst_pkg::ST_UPDATE_DR : bst_pkg::ST_PAUSE_DR;
        bst_pkg::ST_PAUSE_DR:  st_d = tms_s ? bst_pkg::ST_EXIT2_DR : bst_pkg::ST_PAUSE_DR;
        bst_pkg::ST_EXIT2_DR:  st_d = tms_s ? bst_pkg::ST_UPDATE_DR : bst_pkg::ST_SHIFT_DR;
        bst_pkg::ST_UPDATE_DR: st_d = tms_s ? bst_pkg::ST_SEL_DR  : bst_pkg::ST_IDLE;
        // five high edges reach reset from any state [R11]
        bst_pkg::ST_SEL_IR:    st_d = tms_s ? bst_pkg::ST_RESET   : bst_pkg::ST_CAP_IR;
        bst_pkg::ST_CAP_IR:    st_d = tms_s ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
        bst_pkg::ST_SHIFT_IR:  st_d = tms_s ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
        bst_pkg::ST_EXIT1_IR:  st_d = tms_s ? bst_pkg::ST_UPDATE_IR : bst_pkg::ST_PAUSE_IR;
        bst_pkg::ST_PAUSE_IR:  st_d = tms_s ? bst_pkg::ST_EXIT2_IR : bst_pkg::ST_PAUSE_IR;
        bst_pkg::ST_EXIT2_IR:  st_d = tms_s ? bst_pkg::ST_UPDATE_IR : bst_pkg::ST_SHIFT_IR;
        bst_pkg::ST_UPDATE_IR: st_d = tms_s ? bst_pkg::ST_SEL_DR  : bst_pkg::ST_IDLE;
      endcase  // [R1]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // shift registers (rising edge) and update latches (falling edge)
  logic [`BST_IR_WIDTH-1:0] irs_q, irs_d;   // instruction shift stage
  logic [`BST_IR_WIDTH-1:0] ir_q,  ir_d;    // current instruction
  logic                     byp_q, byp_d;
  logic [`BST_ID_WIDTH-1:0] ids_q, ids_d;
  logic [BSR_LEN-1:0]       bsr_q, bsr_d;
  logic [BSR_LEN-1:0]       upd_q, upd_d;
  logic                     tdo_q, tdo_d;
  logic                     oe_q,  oe_d;
  logic                     ext_q, ext_d;
  logic                     hiz_q, hiz_d;
  logic                     dr_bsr;
  logic                     dr_id;
  logic                     sel_out;

  // unknown codes fall back to bypass
  assign dr_bsr = (ir_q == `BST_INS_EXTEST) || (ir_q == `BST_INS_SAMPLE_Z) ||
                  (ir_q == `BST_INS_SAMPLE_PRE);  // [R8]
  assign dr_id  = (ir_q == `BST_INS_IDCODE);

  always_comb begin
    irs_d = irs_q;
    ir_d  = ir_q;
    byp_d = byp_q;
    ids_d = ids_q;
    bsr_d = bsr_q;
    upd_d = upd_q;
    tdo_d = tdo_q;
    oe_d  = oe_q;
    ext_d = ext_q;
    hiz_d = hiz_q;
    sel_out = 1'b0;
    if (rise) begin
      unique case (st_q)
        bst_pkg::ST_CAP_IR:   irs_d = `BST_IR_CAPTURE;  // [R16]
        bst_pkg::ST_SHIFT_IR: irs_d = {tdi_s, irs_q[`BST_IR_WIDTH-1:1]};  // [R9]
        bst_pkg::ST_CAP_DR: begin
          byp_d = 1'b0;  // [R17]
          if (dr_id) ids_d = `BST_ID_VALUE;  // [R18]
          if (dr_bsr) bsr_d = ring_s;
        end
        bst_pkg::ST_SHIFT_DR: begin
          if (dr_id) ids_d = {tdi_s, ids_q[`BST_ID_WIDTH-1:1]};  // [R9] [R18]
          else if (dr_bsr) bsr_d = {tdi_s, bsr_q[BSR_LEN-1:1]};
          else byp_d = tdi_s;  // [R17]
        end
        default: ;
      endcase
    end
    if (fall) begin
      if (st_q == bst_pkg::ST_SHIFT_IR) sel_out = irs_q[0];
      else if (dr_id) sel_out = ids_q[0];
      else if (dr_bsr) sel_out = bsr_q[0];
      else sel_out = byp_q;
      tdo_d = sel_out;  // [R4] [R9]
      oe_d  = (st_q == bst_pkg::ST_SHIFT_IR) || (st_q == bst_pkg::ST_SHIFT_DR);  // [R10]
      if (st_q == bst_pkg::ST_RESET) begin
        ir_d  = `BST_IR_RESET;  // [R15]
        upd_d = '0;
        ext_d = 1'b0;
        hiz_d = 1'b0;
      end else if (st_q == bst_pkg::ST_UPDATE_IR) begin
        ir_d  = irs_q;  // [R19]
        ext_d = (irs_q == `BST_INS_EXTEST);
        hiz_d = (irs_q == `BST_INS_SAMPLE_Z);
      end else if (st_q == bst_pkg::ST_UPDATE_DR && dr_bsr) begin
        upd_d = bsr_q;  // [R19]
      end
    end
  end

  // tap reset only touches test logic, never the memory path [R12]
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tck_q <= 1'b0;
      st_q  <= bst_pkg::ST_RESET;  // [R13]
      irs_q <= `BST_IR_RESET;
      ir_q  <= `BST_IR_RESET;  // [R15]
      byp_q <= 1'b0;
      ids_q <= '0;
      bsr_q <= '0;
      upd_q <= '0;
      tdo_q <= 1'b0;
      oe_q  <= 1'b0;  // [R13]
      ext_q <= 1'b0;
      hiz_q <= 1'b0;
    end else begin
      tck_q <= tck_s;
      st_q  <= st_d;
      irs_q <= irs_d;
      ir_q  <= ir_d;
      byp_q <= byp_d;
      ids_q <= ids_d;
      bsr_q <= bsr_d;
      upd_q <= upd_d;
      tdo_q <= tdo_d;
      oe_q  <= oe_d;
      ext_q <= ext_d;
      hiz_q <= hiz_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops [R2]
  assign tdo_o     = tdo_q;
  assign tdo_oe    = oe_q;
  assign bsr_out   = upd_q;
  assign extest_en = ext_q;
  assign out_hiz   = hiz_q;

endmodule : bst_tap
`default_nettype wire

// ==== bench/bst_tap_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
module bst_tap_checker #(
  parameter int BSR_LEN = 8
) (
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               resetn,
  // test pins and ring controls
  input wire logic               tck,
  input wire logic               tms,
  input wire logic               tms_pu_n,
  input wire logic               tdo_o,
  input wire logic               tdo_oe,
  input wire logic [BSR_LEN-1:0] bsr_out,
  input wire logic               extest_en,
  input wire logic               out_hiz
);
  // resync like the design, so the tms seen at each rise is the same
  logic [2:0] ck_q, ck_d, n_q, n_d;
  logic [1:0] ms_q, ms_d;
  logic       lt_q, lt_d, rise;
  always_comb begin
    ck_d = {ck_q[1:0], tck};
    ms_d = {ms_q[0], tms | tms_pu_n};
    rise = ck_q[1] & ~ck_q[2];
    lt_d = rise ? ms_q[1] : lt_q;
    n_d  = n_q;
    if (rise) n_d = !ms_q[1] ? 3'h0 : (n_q == 3'h5) ? n_q : n_q + 3'h1;
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) {ck_q, ms_q, n_q, lt_q} <= 9'h0;
    else {ck_q, ms_q, n_q, lt_q} <= {ck_d, ms_d, n_d, lt_d};
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  AST_PWRUP_QUIET: assert property ($rose(resetn) |-> !tdo_oe && !extest_en)
    else $error("outputs active after reset");
  AST_OE_ON_FALL: assert property ($changed(tdo_oe) |-> !tck)
    else $error("enable moved while tck high");
  AST_TDO_ON_FALL: assert property ($changed(tdo_o) |-> !tck)
    else $error("tdo moved while tck high");
  AST_UPD_ON_FALL: assert property ($changed({bsr_out, extest_en}) |-> !tck)
    else $error("update while tck high");
  AST_OE_ENTRY: assert property ($rose(tdo_oe) |-> !lt_q)
    else $error("enable without shift entry");
  AST_OE_EXIT: assert property ($fell(tdo_oe) |-> lt_q)
    else $error("enable dropped inside shift");
  AST_TMS_RESET: assert property ($rose(n_q == 3'h5) |-> ##[1:40] (!extest_en && !out_hiz && bsr_out == '0))
    else $error("no reset after five tms highs");
  AST_ONE_MODE: assert property (!(extest_en && out_hiz))
    else $error("two instructions active");
  cover property ($rose(tdo_oe));
  cover property ($rose(extest_en));
  cover property ($rose(n_q == 3'h5));
endmodule : bst_tap_checker
bind bst_tap bst_tap_checker #(.BSR_LEN(BSR_LEN)) chk (
  .clk_sys, .resetn, .tck, .tms, .tms_pu_n, .tdo_o, .tdo_oe, .bsr_out, .extest_en, .out_hiz);
`default_nettype wire

// ==== bench/bst_jtag_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module bst_jtag_host (
  // clock
  input wire logic clk_sys,
  // test pins
  output logic     tck,
  output logic     tms,
  output logic     tdi,
  input wire logic tdo_o,
  input wire logic tdo_oe
);
  initial {tck, tms, tdi} = 3'h3;
  // one 68 ns tck period; tck rests low between steps
  task automatic step(input logic m, input logic d, output logic o, output logic e);
    @(negedge clk_sys);
    tms = m;
    tdi = d;
    repeat (8) @(negedge clk_sys);
    o = tdo_oe ? tdo_o : ~tdo_o;
    e = tdo_oe;
    tck = 1'b1; // tms and tdi steady across the rise
    repeat (8) @(negedge clk_sys);
    tck = 1'b0;
  endtask : step
  task automatic reset5();
    logic o, e;
    repeat (5) step(1'b1, 1'b1, o, e);
  endtask : reset5
endmodule : bst_jtag_host
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "bst_params.svh"
module tb;
  logic        clk_sys  = 1'b0;
  logic        resetn   = 1'b0;
  logic        tms_pu_n = 1'b0;
  logic        tdi_pu_n = 1'b0;
  logic [7:0]  ring_in  = 8'ha5;
  logic        tck, tms, tdi, tdo_o, tdo_oe, extest_en, out_hiz;
  logic [7:0]  bsr_out;
  logic [31:0] d;
  int          miscompares = 0;
  int          num_checks  = 0;
  always #2 clk_sys = ~clk_sys;
  bst_tap #(.BSR_LEN(8)) uut (.clk_sys, .resetn, .tck, .tms, .tms_pu_n, .tdi, .tdi_pu_n,
    .tdo_o, .tdo_oe, .ring_in, .bsr_out, .extest_en, .out_hiz);
  bst_jtag_host host (.clk_sys, .tck, .tms, .tdi, .tdo_o, .tdo_oe);
  ////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // from idle: capture, shift n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic o, e, on;
    on   = 1'b1;
    dout = 32'h0;
    host.step(1'b1, 1'b0, o, e);
    if (ir) host.step(1'b1, 1'b0, o, e);
    repeat (2) host.step(1'b0, 1'b0, o, e);
    for (int i = 0; i < n; i++) begin
      host.step(i == n - 1, din[i], o, e);
      dout[i] = o;
      on &= e;
    end
    check(32'(on), 32'h1);
    host.step(1'b1, 1'b0, o, e);
    check(32'(e), 32'h0);
    host.step(1'b0, 1'b0, o, e);
  endtask : scan
  task automatic ir(input logic [2:0] c);
    scan(1'b1, 3, 32'(c), d);
  endtask : ir
  ////////////////////////////////////////
  task automatic t_power();
    check(32'({tdo_oe, extest_en, out_hiz, bsr_out}), 32'h0);
    $display("power done");
  endtask : t_power
  task automatic t_idcode();
    logic o, e;
    host.reset5();
    host.step(1'b0, 1'b1, o, e);
    scan(1'b0, 32, 32'hffffffff, d);
    check(d, `BST_ID_VALUE);
    $display("idcode done");
  endtask : t_idcode
  task automatic t_bypass();
    logic [2:0] codes [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
    foreach (codes[k]) begin
      ir(codes[k]);
      check(32'(d[1:0]), 32'h1);
      scan(1'b0, 4, 32'hd, d);
      check(d, 32'ha);
    end
    tdi_pu_n = 1'b1;
    scan(1'b0, 4, 32'h0, d);
    check(d, 32'he);
    tdi_pu_n = 1'b0;
    ir(`BST_INS_IDCODE);
    scan(1'b0, 32, 32'h0, d);
    check(d, `BST_ID_VALUE);
    $display("bypass done");
  endtask : t_bypass
  task automatic t_boundary();
    logic o, e;
    ring_in = 8'h3c;
    ir(`BST_INS_SAMPLE_PRE);
    scan(1'b0, 8, 32'h5a, d);
    check(d, 32'h3c);
    check(32'(bsr_out), 32'h5a);
    ir(`BST_INS_EXTEST);
    check(32'({extest_en, out_hiz}), 32'h2);
    ir(`BST_INS_SAMPLE_Z);
    check(32'({extest_en, out_hiz, bsr_out}), 32'h15a);
    tms_pu_n = 1'b1;
    repeat (5) host.step(1'b0, 1'b0, o, e);
    repeat (8) @(negedge clk_sys);
    check(32'({extest_en, out_hiz, bsr_out}), 32'h0);
    tms_pu_n = 1'b0;
    host.step(1'b0, 1'b1, o, e);
    scan(1'b0, 32, 32'h0, d);
    check(d, `BST_ID_VALUE);
    $display("boundary done");
  endtask : t_boundary
  ////////////////////////////////////////
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (16) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_power();
    t_idcode();
    t_bypass();
    t_boundary();
    stop_test();
  end
endmodule : tb
`default_nettype wire
